//--- hw/mac_pkg.sv
// Package: offsets, field layout and timing of the algorithm config bank
// Summary of operation
// - Bit 30 enables speed detection before start-up; resets to 0.
// - Bit 29 enables braking; resets to 0.
// - Bit 28 enables the high-impedance coast state; resets to 0.
// - Bit 27 enables reverse drive; resets to 0.
// - Bit 26 enables resync to a spinning motor; resets to 0.
// - Bits 25-22 give resync minimum speed, 5% to 60%, then 70-100%.
// - Bit 21 picks brake FETs: 0 all high side, 1 all low side.
// - Bit 20: 0 exits brake on time, 1 on current threshold and time.
// - Bits 19-17 give brake current threshold, 0.0625 A to 5.0 A.
// - Bits 16-13 give brake time, 10 ms to 15 s.
// - Bits 12-9 give coast time on the same scale as brake time.
// - Bits 8-6 give stationary back-EMF level, 50 mV to 1500 mV.
// - Bits 5-2 give reverse hand-over speed, 2.5% to 100%.
// - Bits 1-0 give reversal open-loop current, 0.9375 A to 3.125 A.
package mac_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         WORDS = 14;
  localparam logic [7:0] WORD_OFFSET [WORDS] = '{
    8'h80, 8'h82, 8'h84, 8'h86, 8'h88, 8'h8A, 8'h8C,
    8'h8E, 8'h94, 8'h96, 8'h98, 8'h9A, 8'h9C, 8'h9E};
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  // ----------------------------------------------------------------
  // Speed-detect word fields
  // ----------------------------------------------------------------
  localparam int DETECT_BIT   = 30;
  localparam int BRAKE_BIT    = 29;
  localparam int COAST_BIT    = 28;
  localparam int REVERSE_BIT  = 27;
  localparam int RESYNC_BIT   = 26;
  localparam int RSPEED_LSB   = 22;
  localparam int FET_BIT      = 21;
  localparam int EXIT_BIT     = 20;
  localparam int BCUR_LSB     = 17;
  localparam int BTIME_LSB    = 13;
  localparam int CTIME_LSB    = 9;
  localparam int BEMF_LSB     = 6;
  localparam int RVSPEED_LSB  = 2;
  localparam int RVCUR_LSB    = 0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int DUR_W         = 14;
  typedef enum logic [1:0] {ST_IDLE, ST_BRAKE, ST_COAST} mac_phase_t;
endpackage : mac_pkg

//--- hw/mac_isd_decode.sv
// Module: code-to-unit translation of the speed-detect word fields
`timescale 1ns/1ns
module mac_isd_decode
  import mac_pkg::*;
(
  input  wire logic [31:0]      isdWord,
  output wire logic [9:0]       resyncMinSpeed,
  output wire logic [15:0]      brakeCurrentLimit,
  output wire logic [DUR_W-1:0] brakeDuration,
  output wire logic [DUR_W-1:0] coastDuration,
  output wire logic [10:0]      stationaryBemfLevel,
  output wire logic [9:0]       reversalOpenLoopSpeed,
  output wire logic [15:0]      reversalCurrentLimit
);
  // Percent in tenths, current in tenths of mA, time in ms, level in mV
  function automatic logic [DUR_W-1:0] timeMs(input logic [3:0] c);
    case (c)
      4'h0: timeMs = 14'd10;    4'h1: timeMs = 14'd50;
      4'h2: timeMs = 14'd100;   4'h3: timeMs = 14'd200;
      4'h4: timeMs = 14'd300;   4'h5: timeMs = 14'd400;
      4'h6: timeMs = 14'd500;   4'h7: timeMs = 14'd750;
      4'h8: timeMs = 14'd1000;  4'h9: timeMs = 14'd2000;
      4'hA: timeMs = 14'd3000;  4'hB: timeMs = 14'd4000;
      4'hC: timeMs = 14'd5000;  4'hD: timeMs = 14'd7500;
      4'hE: timeMs = 14'd10000; default: timeMs = 14'd15000;
    endcase
  endfunction : timeMs

  function automatic logic [9:0] rvSpeed(input logic [3:0] c);
    case (c)
      4'h0: rvSpeed = 10'd25;  4'h1: rvSpeed = 10'd50;
      4'h2: rvSpeed = 10'd75;  4'h3: rvSpeed = 10'd100;
      4'h4: rvSpeed = 10'd125; 4'h5: rvSpeed = 10'd150;
      4'h6: rvSpeed = 10'd200; 4'h7: rvSpeed = 10'd250;
      4'h8: rvSpeed = 10'd300; 4'h9: rvSpeed = 10'd400;
      4'hA: rvSpeed = 10'd500; 4'hB: rvSpeed = 10'd600;
      4'hC: rvSpeed = 10'd700; 4'hD: rvSpeed = 10'd800;
      4'hE: rvSpeed = 10'd900; default: rvSpeed = 10'd1000;
    endcase
  endfunction : rvSpeed

  function automatic logic [15:0] bCur(input logic [2:0] c);
    case (c)
      3'h0: bCur = 16'd625;   3'h1: bCur = 16'd1250;
      3'h2: bCur = 16'd1875;  3'h3: bCur = 16'd3125;
      3'h4: bCur = 16'd6250;  3'h5: bCur = 16'd12500;
      3'h6: bCur = 16'd25000; default: bCur = 16'd50000;
    endcase
  endfunction : bCur

  function automatic logic [10:0] bemf(input logic [2:0] c);
    case (c)
      3'h0: bemf = 11'd50;   3'h1: bemf = 11'd75;
      3'h2: bemf = 11'd100;  3'h3: bemf = 11'd250;
      3'h4: bemf = 11'd500;  3'h5: bemf = 11'd750;
      3'h6: bemf = 11'd1000; default: bemf = 11'd1500;
    endcase
  endfunction : bemf

  wire logic [3:0] rsCode = isdWord[RSPEED_LSB +: 4];
  wire logic [1:0] rcCode = isdWord[RVCUR_LSB +: 2];

  // Steps of 5% up to Bh, then 10% steps
  assign resyncMinSpeed = (rsCode <= 4'hB)
    ? 10'(({6'd0, rsCode} + 10'd1) * 10'd50)
    : 10'(({6'd0, rsCode} - 10'd5) * 10'd100);
  assign brakeCurrentLimit = bCur(isdWord[BCUR_LSB +: 3]);
  assign brakeDuration = timeMs(isdWord[BTIME_LSB +: 4]);
  assign coastDuration = timeMs(isdWord[CTIME_LSB +: 4]);
  assign stationaryBemfLevel = bemf(isdWord[BEMF_LSB +: 3]);
  assign reversalOpenLoopSpeed = rvSpeed(isdWord[RVSPEED_LSB +: 4]);
  assign reversalCurrentLimit = (rcCode == 2'h3) ? 16'd31250
    : 16'(16'd9375 + {14'd0, rcCode} * 16'd6250);
endmodule : mac_isd_decode

//--- hw/mac_ms_timer.sv
// Module: millisecond interval timer for brake and coast phases
`timescale 1ns/1ns
module mac_ms_timer
  import mac_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [DUR_W-1:0] durMs,
  output logic                  running,
  output logic                  expired
);
  localparam int DW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;
  logic [DW-1:0]    div_q;
  logic [DUR_W-1:0] cnt_q;
  logic [DUR_W-1:0] dur_q;
  wire logic msTick  = running && (div_q == DW'(MS_CYC - 1));
  wire logic lastMs  = msTick && (cnt_q + 14'd1 == dur_q);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || abort || start || msTick) begin
      div_q <= '0;
    end else if (running) begin
      div_q <= div_q + DW'(1);
    end
  end

  // Restart wins over a pending expiry so a new phase is never cut short
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      running <= 1'b0;
      expired <= 1'b0;
      cnt_q   <= '0;
      dur_q   <= '0;
    end else begin
      expired <= lastMs && !start && !abort;
      if (start) begin
        running <= 1'b1;
        cnt_q   <= '0;
        dur_q   <= durMs;
      end else if (abort || lastMs) begin
        running <= 1'b0;
      end else if (msTick) begin
        cnt_q <= cnt_q + 14'd1;
      end
    end
  end

  a_timer_expiry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    expired |-> $past(running) && !running)
    else $error("timer expiry without a running interval");
endmodule : mac_ms_timer

//--- hw/mac_cfg_regs.sv
// Module: algorithm configuration register bank with brake/coast sequencer
`timescale 1ns/1ns
module mac_cfg_regs
  import mac_pkg::*;
#(
  parameter int MS_CYC = mac_pkg::MS_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      regWrEn,
  input  wire logic                      regRdEn,
  input  wire logic [7:0]                regAddr,
  input  wire logic [31:0]               regWrData,
  output logic      [31:0]               regRdData,
  output logic                           regRdValid,
  input  wire logic                      brakeReq,
  input  wire logic                      coastReq,
  input  wire logic [15:0]               brakeCurrent,
  output wire logic                      speedDetectOn,
  output wire logic                      brakeAllowed,
  output wire logic                      coastAllowed,
  output wire logic                      reverseDriveAllowed,
  output wire logic                      resyncAllowed,
  output wire logic                      brakeFetSelect,
  output wire logic                      brakeExitRule,
  output logic      [9:0]                resyncMinSpeed,
  output logic      [15:0]               brakeCurrentLimit,
  output logic      [mac_pkg::DUR_W-1:0] brakeDuration,
  output logic      [mac_pkg::DUR_W-1:0] coastDuration,
  output logic      [10:0]               stationaryBemfLevel,
  output logic      [9:0]                reversalOpenLoopSpeed,
  output logic      [15:0]               reversalCurrentLimit,
  output logic                           brakeHighOn,
  output logic                           brakeLowOn,
  output logic                           coastActive,
  output logic                           brakeDone,
  output logic                           coastDone
);
  // ----------------------------------------------------------------
  // Storage and address decode
  // ----------------------------------------------------------------
  logic [31:0]     word_q [WORDS];
  logic [WORDS-1:0] hit;
  logic [31:0]     rdMux;

  for (genvar i = 0; i < WORDS; i++) begin : g_word
    assign hit[i] = (regAddr == WORD_OFFSET[i]);
    // Whole word stored, reserved bit 31 included
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        word_q[i] <= WORD_RESET;
      end else if (regWrEn && hit[i]) begin
        word_q[i] <= regWrData;
      end
    end
  end

  wire logic        anyHit  = |hit;
  wire logic        wrIsd   = regWrEn && hit[0];
  wire logic [31:0] isdWord = word_q[0];

  always_comb begin
    rdMux = '0;
    for (int i = 0; i < WORDS; i++) begin
      if (hit[i]) begin
        rdMux = word_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Offsets outside the map hold nothing: writes drop, reads give zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdData  <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= anyHit ? rdMux : 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable bits, straight from the stored word
  // ----------------------------------------------------------------
  assign speedDetectOn       = isdWord[DETECT_BIT];
  assign brakeAllowed        = isdWord[BRAKE_BIT];
  assign coastAllowed        = isdWord[COAST_BIT];
  assign reverseDriveAllowed = isdWord[REVERSE_BIT];
  assign resyncAllowed       = isdWord[RESYNC_BIT];
  assign brakeFetSelect      = isdWord[FET_BIT];
  assign brakeExitRule       = isdWord[EXIT_BIT];

  // ----------------------------------------------------------------
  // Decoded field values
  // ----------------------------------------------------------------
  logic [9:0]       rsSpeedD;
  logic [15:0]      bCurD;
  logic [DUR_W-1:0] bTimeD;
  logic [DUR_W-1:0] cTimeD;
  logic [10:0]      bemfD;
  logic [9:0]       rvSpeedD;
  logic [15:0]      rvCurD;

  mac_isd_decode u_decode (
    .isdWord               (isdWord),
    .resyncMinSpeed        (rsSpeedD),
    .brakeCurrentLimit     (bCurD),
    .brakeDuration         (bTimeD),
    .coastDuration         (cTimeD),
    .stationaryBemfLevel   (bemfD),
    .reversalOpenLoopSpeed (rvSpeedD),
    .reversalCurrentLimit  (rvCurD)
  );

  // One cycle behind the stored word so every output is a flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resyncMinSpeed        <= '0;
      brakeCurrentLimit     <= '0;
      brakeDuration         <= '0;
      coastDuration         <= '0;
      stationaryBemfLevel   <= '0;
      reversalOpenLoopSpeed <= '0;
      reversalCurrentLimit  <= '0;
    end else begin
      resyncMinSpeed        <= rsSpeedD;
      brakeCurrentLimit     <= bCurD;
      brakeDuration         <= bTimeD;
      coastDuration         <= cTimeD;
      stationaryBemfLevel   <= bemfD;
      reversalOpenLoopSpeed <= rvSpeedD;
      reversalCurrentLimit  <= rvCurD;
    end
  end

  // ----------------------------------------------------------------
  // Brake / coast sequencer
  // ----------------------------------------------------------------
  mac_phase_t state_q;
  mac_phase_t state_d;
  logic       tmrRun;
  logic       tmrExpired;

  wire logic inIdle   = (state_q == ST_IDLE);
  wire logic inBrake  = (state_q == ST_BRAKE);
  wire logic inCoast  = (state_q == ST_COAST);
  // Decoded from the stored word, not the output flops, so a request in
  // the cycle after a write already brakes with the new settings
  wire logic curBelow = (brakeCurrent < bCurD);
  // Current can only end a brake early; the timer is always the backstop
  wire logic brakeExit = tmrExpired || (brakeExitRule && curBelow);
  wire logic goBrake  = inIdle && brakeReq && brakeAllowed;
  wire logic goCoast  = inIdle && !brakeReq && coastReq && coastAllowed;
  wire logic tmrStart = goBrake || goCoast;
  wire logic tmrAbort = inBrake && brakeExit;
  wire logic [DUR_W-1:0] tmrDur = goBrake ? bTimeD : cTimeD;

  mac_ms_timer #(
    .MS_CYC (MS_CYC)
  ) u_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (tmrStart),
    .abort   (tmrAbort),
    .durMs   (tmrDur),
    .running (tmrRun),
    .expired (tmrExpired)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (goBrake) begin
          state_d = ST_BRAKE;
        end else if (goCoast) begin
          state_d = ST_COAST;
        end
      end
      ST_BRAKE: begin
        if (brakeExit) begin
          state_d = ST_IDLE;
        end
      end
      ST_COAST: begin
        if (tmrExpired) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // A refused request still answers with its done pulse
  wire logic brakeDoneD = (inIdle && brakeReq && !brakeAllowed)
                       || (inBrake && brakeExit);
  wire logic coastDoneD = (inIdle && !brakeReq && coastReq && !coastAllowed)
                       || (inCoast && tmrExpired);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      brakeHighOn <= 1'b0;
      brakeLowOn  <= 1'b0;
      coastActive <= 1'b0;
      brakeDone   <= 1'b0;
      coastDone   <= 1'b0;
    end else begin
      state_q     <= state_d;
      brakeHighOn <= (state_d == ST_BRAKE) && !brakeFetSelect;
      brakeLowOn  <= (state_d == ST_BRAKE) && brakeFetSelect;
      coastActive <= (state_d == ST_COAST);
      brakeDone   <= brakeDoneD;
      coastDone   <= coastDoneD;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence sBrakeEnter;
    inIdle && brakeReq && brakeAllowed;
  endsequence
  sequence sBrakeTimeout;
    inBrake && !brakeExitRule && tmrExpired;
  endsequence

  a_unmapped_read_zero: assert property (
    regRdEn && !anyHit |=> regRdValid && regRdData == 32'h00000000)
    else $error("unmapped offset did not read zero");
  a_detect_bit_set: assert property (
    wrIsd && regWrData[DETECT_BIT] |=> speedDetectOn)
    else $error("speed detect enable not taken from write");
  a_brake_refused: assert property (
    inIdle && brakeReq && !brakeAllowed
    |=> brakeDone && !brakeHighOn && !brakeLowOn)
    else $error("disabled brake did not answer at once");
  a_coast_entry: assert property (
    inIdle && !brakeReq && coastReq && coastAllowed |=> coastActive)
    else $error("coast not entered when allowed");
  a_reverse_bit: assert property (
    wrIsd |=> reverseDriveAllowed == $past(regWrData[REVERSE_BIT]))
    else $error("reverse drive enable wrong after write");
  a_resync_bit: assert property (
    wrIsd |=> resyncAllowed == $past(regWrData[RESYNC_BIT]))
    else $error("resync enable wrong after write");
  a_resync_top_code: assert property (
    wrIsd && regWrData[RSPEED_LSB +: 4] == 4'hF
    |=> ##1 resyncMinSpeed == 10'd1000)
    else $error("resync speed code Fh not 100 percent");
  a_brake_fet_pick: assert property (
    sBrakeEnter |=> brakeHighOn == !$past(brakeFetSelect)
                    && brakeLowOn == $past(brakeFetSelect))
    else $error("wrong brake FET group");
  a_brake_timeout: assert property (
    sBrakeTimeout |=> brakeDone && inIdle && !brakeHighOn && !brakeLowOn)
    else $error("brake did not end on time expiry");
  a_brake_current_exit: assert property (
    inBrake && brakeExitRule && curBelow |=> brakeDone && inIdle)
    else $error("brake did not end on current threshold");
  a_brake_time_code: assert property (
    isdWord[BTIME_LSB +: 4] == 4'hD |=> brakeDuration == 14'd7500)
    else $error("brake time code Dh not 7.5 s");
  a_bemf_top_code: assert property (
    isdWord[BEMF_LSB +: 3] == 3'h7 |=> stationaryBemfLevel == 11'd1500)
    else $error("stationary level code 7h not 1500 mV");
  a_word_readback: assert property (
    wrIsd ##1 (regRdEn && hit[0] && !regWrEn)
    |=> regRdData == $past(regWrData, 2))
    else $error("speed detect word did not read back");
endmodule : mac_cfg_regs

//--- testbench/mac_host_model.sv
// Host model: register-port master standing in for the external host
`timescale 1ns/1ns
module mac_host_model (
  input  wire logic        clk_sys,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic [7:0]       regAddr,
  output logic [31:0]      regWrData,
  input  wire logic [31:0] regRdData,
  input  wire logic        regRdValid
);
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 32'h00000000;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released lines show the inverse, so a stale sample cannot pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input bit mayReserved);
    if (!mayReserved && (a[0] || !(a inside {[8'h80:8'h8E],
        [8'h94:8'h9E]}))) begin
      return;
    end
    @(posedge clk_sys);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrEn   <= 1'b0;
    regAddr   <= ~a;
    regWrData <= ~d;
  endtask : wr
  // Write, then read the same offset in the very next cycle
  task automatic wrRd(input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrEn   <= 1'b0;
    regWrData <= ~d;
    regRdEn   <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    @(posedge clk_sys);
    q = (regRdValid === 1'b1) ? regRdData : 32'hXXXXXXXX;
  endtask : wrRd
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    d = 32'hXXXXXXXX;
    @(posedge clk_sys);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      if (regRdValid === 1'b1) begin
        d = regRdData;
        break;
      end
    end
  endtask : rd
endmodule : mac_host_model

//--- testbench/tb_top.sv
// Testbench: speed-detect word fields, register bank and brake/coast
`timescale 1ns/1ns
module tb_top;
  import mac_pkg::*;
  localparam int RSP [16] = '{50, 100, 150, 200, 250, 300, 350, 400,
                              450, 500, 550, 600, 700, 800, 900, 1000};
  localparam int BCU [8] = '{625, 1250, 1875, 3125, 6250, 12500,
                             25000, 50000};
  localparam int DUR [16] = '{10, 50, 100, 200, 300, 400, 500, 750,
                              1000, 2000, 3000, 4000, 5000, 7500,
                              10000, 15000};
  localparam int BEM [8] = '{50, 75, 100, 250, 500, 750, 1000, 1500};
  localparam int RVS [16] = '{25, 50, 75, 100, 125, 150, 200, 250,
                              300, 400, 500, 600, 700, 800, 900, 1000};
  localparam int RVC [4] = '{9375, 15625, 21875, 31250};
  typedef struct {
    logic [31:0] w;
    logic [31:0] rsp, bcu, btm, ctm, bem, rvs, rvc;
  } mac_row_t;
  logic                 clk_sys, sysRst, brakeReq, coastReq;
  logic                 regWrEn, regRdEn, regRdValid;
  logic [7:0]           regAddr;
  logic [31:0]          regWrData, regRdData, rdWord;
  logic [15:0]          brakeCurrent, brakeCurrentLimit;
  logic [15:0]          reversalCurrentLimit;
  logic                 speedDetectOn, brakeAllowed, coastAllowed;
  logic                 reverseDriveAllowed, resyncAllowed;
  logic                 brakeFetSelect, brakeExitRule;
  logic [9:0]           resyncMinSpeed, reversalOpenLoopSpeed;
  logic [DUR_W-1:0]     brakeDuration, coastDuration;
  logic [10:0]          stationaryBemfLevel;
  logic                 brakeHighOn, brakeLowOn, coastActive;
  logic                 brakeDone, coastDone;
  int                   errorCnt, compares;
  mac_row_t             rows [16];
  // ----------------------------------------------------------------
  // Clock, instances
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  mac_host_model host (.clk_sys(clk_sys), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid));
  mac_cfg_regs #(.MS_CYC(10)) dut (.clk_sys(clk_sys), .sys_rst(sysRst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .brakeReq(brakeReq), .coastReq(coastReq),
    .brakeCurrent(brakeCurrent), .speedDetectOn(speedDetectOn),
    .brakeAllowed(brakeAllowed), .coastAllowed(coastAllowed),
    .reverseDriveAllowed(reverseDriveAllowed),
    .resyncAllowed(resyncAllowed), .brakeFetSelect(brakeFetSelect),
    .brakeExitRule(brakeExitRule), .resyncMinSpeed(resyncMinSpeed),
    .brakeCurrentLimit(brakeCurrentLimit),
    .brakeDuration(brakeDuration), .coastDuration(coastDuration),
    .stationaryBemfLevel(stationaryBemfLevel),
    .reversalOpenLoopSpeed(reversalOpenLoopSpeed),
    .reversalCurrentLimit(reversalCurrentLimit),
    .brakeHighOn(brakeHighOn), .brakeLowOn(brakeLowOn),
    .coastActive(coastActive), .brakeDone(brakeDone),
    .coastDone(coastDone));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic endTest(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, errorCnt);
  endtask : endTest
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : printVerdict
  // Fields get unrelated codes, except resync speed and brake time (both c), brake current (c[2:0]) and reverse current (c[1:0])
  function automatic logic [31:0] rowWord(input logic [3:0] c);
    return {c[0], c[1], c[2], c[3], ~c[0], ~c[1], c, c[2] ^ c[0],
            c[3] ^ c[1], c[2:0], c, 4'hF - c, 3'(c + 4'd3),
            4'(c + 4'd5), c[1:0]};
  endfunction : rowWord
  function automatic mac_row_t mkRow(input logic [31:0] w);
    mac_row_t r;
    r.w = w;
    r.rsp = RSP[w[25:22]];
    r.bcu = BCU[w[19:17]];
    r.btm = DUR[w[16:13]];
    r.ctm = DUR[w[12:9]];
    r.bem = BEM[w[8:6]];
    r.rvs = RVS[w[5:2]];
    r.rvc = RVC[w[1:0]];
    return r;
  endfunction : mkRow
  task automatic chkRow(input mac_row_t r);
    chk("detect on", speedDetectOn, r.w[30]);
    chk("brake on", brakeAllowed, r.w[29]);
    chk("coast on", coastAllowed, r.w[28]);
    chk("reverse on", reverseDriveAllowed, r.w[27]);
    chk("resync on", resyncAllowed, r.w[26]);
    chk("resync speed", resyncMinSpeed, r.rsp);
    chk("fet group", brakeFetSelect, r.w[21]);
    chk("exit rule", brakeExitRule, r.w[20]);
    chk("brake current", brakeCurrentLimit, r.bcu);
    chk("brake time", brakeDuration, r.btm);
    chk("coast time", coastDuration, r.ctm);
    chk("bemf level", stationaryBemfLevel, r.bem);
    chk("reverse speed", reversalOpenLoopSpeed, r.rvs);
    chk("reverse current", reversalCurrentLimit, r.rvc);
  endtask : chkRow
  // Counts edges from the taken request until the done pulse
  task automatic phaseCase(input logic [31:0] w, input bit brk,
                           input logic [15:0] cur, input int lo, hi,
                           input logic [2:0] expSeen);
    int n;
    logic [2:0] seen;
    n = 0;
    seen = 3'b000;
    host.wr(8'h80, w, 1'b0);
    brakeCurrent <= cur;
    @(posedge clk_sys);
    brakeReq <= brk;
    coastReq <= !brk;
    @(posedge clk_sys);
    brakeReq <= 1'b0;
    coastReq <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
      seen |= {brakeHighOn, brakeLowOn, coastActive};
    end while ((brk ? brakeDone : coastDone) !== 1'b1 && n < 3000);
    chk("phase length in range", 32'(n >= lo && n <= hi), 32'd1);
    chk("active outputs", {29'd0, seen}, {29'd0, expSeen});
  endtask : phaseCase
  task automatic chkAllZero;
    foreach (WORD_OFFSET[k]) begin
      host.rd(WORD_OFFSET[k], rdWord);
      chk("word after reset", rdWord, WORD_RESET);
    end
  endtask : chkAllZero
  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    errorCnt++;
    printVerdict();
  end
  initial begin
    sysRst = 1'b1;
    brakeReq = 1'b0;
    coastReq = 1'b0;
    brakeCurrent = 16'h0000;
    errorCnt = 0;
    compares = 0;
    for (int i = 0; i < 16; i++) begin
      rows[i] = mkRow(rowWord(4'(i)));
    end
    repeat (2) @(posedge clk_sys);
    sysRst <= 1'b0;
    foreach (rows[i]) begin
      host.wr(8'h80, rows[i].w, 1'b0);
      repeat (2) @(posedge clk_sys);
      chkRow(rows[i]);
      host.rd(8'h80, rdWord);
      chk("speed-detect word", rdWord, rows[i].w);
    end
    endTest("field decode");
    foreach (WORD_OFFSET[k]) begin
      host.wr(WORD_OFFSET[k], {8'hA5, WORD_OFFSET[k], 16'h5A0F}, 1'b0);
    end
    host.wr(8'h90, 32'hFFFFFFFF, 1'b1);
    host.wr(8'h81, 32'hFFFFFFFF, 1'b1);
    foreach (WORD_OFFSET[k]) begin
      host.rd(WORD_OFFSET[k], rdWord);
      chk("bank word", rdWord, {8'hA5, WORD_OFFSET[k], 16'h5A0F});
    end
    host.rd(8'h90, rdWord);
    chk("unmapped 90h", rdWord, 32'h00000000);
    host.rd(8'h81, rdWord);
    chk("unmapped 81h", rdWord, 32'h00000000);
    host.wrRd(8'h80, 32'h80000001, rdWord);
    chk("write then read", rdWord, 32'h80000001);
    endTest("bank access");
    @(posedge clk_sys);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sysRst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chkRow(mkRow(WORD_RESET));
    chkAllZero();
    endTest("reset");
    phaseCase(32'h00000000, 1'b1, 16'd0, 1, 2, 3'b000);
    phaseCase(32'h20000000, 1'b1, 16'd0, 100, 106, 3'b100);
    phaseCase(32'h20202000, 1'b1, 16'd0, 500, 506, 3'b010);
    phaseCase(32'h20300000, 1'b1, 16'd0, 2, 8, 3'b010);
    phaseCase(32'h201E0000, 1'b1, 16'd49999, 2, 8, 3'b100);
    phaseCase(32'h20100000, 1'b1, 16'd626, 100, 106, 3'b100);
    endTest("brake");
    phaseCase(32'h00000000, 1'b0, 16'd0, 1, 2, 3'b000);
    phaseCase(32'h10000400, 1'b0, 16'd0, 1000, 1006, 3'b001);
    endTest("coast");
    printVerdict();
  end
endmodule : tb_top
